//--- hw/fifo_flags_consts.svh
// register offsets, field positions, reset values and counts for the fifo status block
`ifndef FIFO_FLAGS_CONSTS_SVH
`define FIFO_FLAGS_CONSTS_SVH

// ============================================================
// register offsets
`define FFL_ADDR_STATUS 10'h000
`define FFL_ADDR_SLOTS 10'h001
`define FFL_ADDR_LIMIT 10'h006
`define FFL_ADDR_ACLEAR 10'h007
`define FFL_ADDR_DATA 10'h02F

// ============================================================
// status register fields
`define FFL_BIT_FLUSH 15
`define FFL_BIT_UNDER 14
`define FFL_BIT_OVER 13
`define FFL_BIT_FILL 12
`define FFL_BIT_INIT 11
`define FFL_COUNT_MSB 10
`define FFL_COUNT_W 11

// ============================================================
// limit and autoclear registers
`define FFL_LIMIT_W 10
`define FFL_LIMIT_RESET 10'h00C
`define FFL_BIT_ACLEAR 15
`define FFL_ACLEAR_RESET 1'b1

// ============================================================
// sizes
`define FFL_SLOT_COUNT 12
`define FFL_FIFO_DEPTH 16
`define FFL_FIFO_WIDTH 8
`define FFL_REG_W 16
`define FFL_ADDR_W 10

`endif

//--- hw/fifo_flags_pkg.sv
// types shared by the fifo status block
`include "fifo_flags_consts.svh"
package fifo_flags_pkg;
    // one register access from the serial port's register engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`FFL_ADDR_W-1:0] addr;
        logic [`FFL_REG_W-1:0] wdata;
    } reg_req_t;

    // read answer towards the serial port
    typedef struct packed {
        logic valid;
        logic [`FFL_REG_W-1:0] data;
    } reg_rsp_t;

    // fifo self-initialisation phases
    typedef enum logic [0:0] {
        INIT_RUNNING = 1'b0,
        INIT_DONE = 1'b1
    } init_state_t;
endpackage

//--- hw/byte_fifo.sv
// flip-flop fifo with valid/ready on both sides and a flush input
`timescale 1ns/10ps
`include "fifo_flags_consts.svh"
module byte_fifo #(
    parameter int WIDTH = `FFL_FIFO_WIDTH,
    parameter int DEPTH = `FFL_FIFO_DEPTH,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // control
    input wire logic enable,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // occupancy in words
    output logic [CW-1:0] count
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];   // storage, indexed by pointer
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic push;
    logic pop;
    logic [CW-1:0] next_count;

    // accepted handshakes; flush blocks both so it never races a transfer
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // next occupancy
    always_comb begin
        next_count = count;
        if (flush) begin
            next_count = '0;
        end else if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    // occupancy and registered ready; ready looks one word ahead
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= enable && !flush && (next_count != CW'(DEPTH));
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge ref_clk) begin
        if (srst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
        end
    end

    // storage written only on accepted words
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

//--- hw/fifo_flags_top.sv
// fifo status flags, occupancy, fill limit and per-slot level-0 flags
`timescale 1ns/10ps
`include "fifo_flags_consts.svh"
module fifo_flags_top #(
    parameter int DEPTH = `FFL_FIFO_DEPTH,
    parameter int WIDTH = `FFL_FIFO_WIDTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register access from the serial port engine
    input wire fifo_flags_pkg::reg_req_t reg_req,
    output fifo_flags_pkg::reg_rsp_t reg_rsp,
    // sample stream from the acquisition path
    input wire logic acq_busy,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // slot events from the data path
    input wire logic [`FFL_SLOT_COUNT-1:0] slot_update_hit,
    input wire logic [`FFL_SLOT_COUNT-1:0] tia1_sat_hit,
    // flag levels for the interrupt router
    output logic queue_fill_flag,
    output logic [`FFL_SLOT_COUNT-1:0] slot_flags_reg
);
    localparam int CW = $clog2(DEPTH + 1);

    // ============================================================
    // state
    fifo_flags_pkg::init_state_t init_state; // self-init progress
    logic [CW-1:0] init_cnt;                 // entries swept so far
    logic queue_underrun_flag;
    logic queue_overrun_flag;
    logic [`FFL_LIMIT_W-1:0] queue_fill_limit;
    logic fill_flag_autoclear_en;

    // fifo wiring
    logic fifo_out_valid;
    logic [WIDTH-1:0] fifo_out_data;
    logic [CW-1:0] fifo_count;
    logic [`FFL_COUNT_W-1:0] byte_count;
    logic [`FFL_COUNT_W-1:0] next_byte_count;

    // decoded strobes
    logic wr_status;
    logic wr_slots;
    logic wr_limit;
    logic wr_aclear;
    logic rd_data;
    logic flush;
    logic push;
    logic drop;
    logic pop;
    logic [`FFL_REG_W-1:0] next_rdata;

    // ============================================================
    // address decode
    always_comb begin
        wr_status = 1'b0;
        wr_slots = 1'b0;
        wr_limit = 1'b0;
        wr_aclear = 1'b0;
        rd_data = 1'b0;
        if (reg_req.wr && reg_req.addr == `FFL_ADDR_STATUS) begin
            wr_status = 1'b1;
        end else if (reg_req.wr && reg_req.addr == `FFL_ADDR_SLOTS) begin
            wr_slots = 1'b1;
        end else if (reg_req.wr && reg_req.addr == `FFL_ADDR_LIMIT) begin
            wr_limit = 1'b1;
        end else if (reg_req.wr && reg_req.addr == `FFL_ADDR_ACLEAR) begin
            wr_aclear = 1'b1;
        end else if (reg_req.rd && reg_req.addr == `FFL_ADDR_DATA) begin
            rd_data = 1'b1;
        end
    end

    // flush is honoured only while acquisition is idle
    assign flush = wr_status && reg_req.wdata[`FFL_BIT_FLUSH] && !acq_busy;
    // a word is one byte wide here, so words and bytes coincide
    assign push = in_valid && in_ready && !flush;
    // the source ignored back-pressure: the word is lost
    assign drop = in_valid && !in_ready;
    // an empty read pops nothing, so the count stays at zero
    assign pop = rd_data && fifo_out_valid && !flush;
    assign byte_count = `FFL_COUNT_W'(fifo_count);
    assign next_byte_count = byte_count + `FFL_COUNT_W'(1);

    // ============================================================
    // fifo in the sample path
    byte_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .CW(CW)
    ) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .enable(init_state == fifo_flags_pkg::INIT_DONE),
        .flush(flush),
        .in_valid(in_valid),
        .in_data(in_data),
        .in_ready(in_ready),
        .out_valid(fifo_out_valid),
        .out_ready(rd_data),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // ============================================================
    // self-initialisation: sweep every entry once before taking data
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            init_state <= fifo_flags_pkg::INIT_RUNNING;
            init_cnt <= '0;
        end else begin
            case (init_state)
                fifo_flags_pkg::INIT_RUNNING: begin
                    if (init_cnt == CW'(DEPTH - 1)) begin
                        init_state <= fifo_flags_pkg::INIT_DONE;
                    end else begin
                        init_cnt <= init_cnt + CW'(1);
                    end
                end
                default: begin
                    init_state <= fifo_flags_pkg::INIT_DONE;
                end
            endcase
        end
    end

    // ============================================================
    // underflow: set on empty data read; the set wins over any clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            queue_underrun_flag <= 1'b0;
        end else if (rd_data && !fifo_out_valid) begin
            queue_underrun_flag <= 1'b1;
        end else if (flush || (wr_status && reg_req.wdata[`FFL_BIT_UNDER])) begin
            queue_underrun_flag <= 1'b0;
        end
    end

    // overflow: set whenever an offered word is dropped
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            queue_overrun_flag <= 1'b0;
        end else if (drop) begin
            queue_overrun_flag <= 1'b1;
        end else if (flush || (wr_status && reg_req.wdata[`FFL_BIT_OVER])) begin
            queue_overrun_flag <= 1'b0;
        end
    end

    // fill flag: compared only on writes, so draining below the limit
    // does not clear it by itself
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            queue_fill_flag <= 1'b0;
        end else if (push && next_byte_count > `FFL_COUNT_W'(queue_fill_limit)) begin
            queue_fill_flag <= 1'b1;
        end else if (flush || (wr_status && reg_req.wdata[`FFL_BIT_FILL])) begin
            queue_fill_flag <= 1'b0;
        end else if (rd_data && fill_flag_autoclear_en) begin
            queue_fill_flag <= 1'b0;
        end
    end

    // ============================================================
    // host-programmed limit and autoclear enable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            queue_fill_limit <= `FFL_LIMIT_RESET;
            fill_flag_autoclear_en <= `FFL_ACLEAR_RESET;
        end else begin
            if (wr_limit) begin
                queue_fill_limit <= reg_req.wdata[`FFL_LIMIT_W-1:0];
            end
            if (wr_aclear) begin
                fill_flag_autoclear_en <= reg_req.wdata[`FFL_BIT_ACLEAR];
            end
        end
    end

    // ============================================================
    // slot flags, bit n is slot A+n; an event beats a same-cycle clear
    for (genvar s = 0; s < `FFL_SLOT_COUNT; s++) begin : g_slot
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                slot_flags_reg[s] <= 1'b0;
            end else if (slot_update_hit[s] || tia1_sat_hit[s]) begin
                slot_flags_reg[s] <= 1'b1;
            end else if (wr_slots && reg_req.wdata[s]) begin
                slot_flags_reg[s] <= 1'b0;
            end
        end
    end

    // ============================================================
    // read data mux; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        if (reg_req.addr == `FFL_ADDR_STATUS) begin
            // flush bit always reads zero
            next_rdata[`FFL_BIT_UNDER] = queue_underrun_flag;
            next_rdata[`FFL_BIT_OVER] = queue_overrun_flag;
            next_rdata[`FFL_BIT_FILL] = queue_fill_flag;
            next_rdata[`FFL_BIT_INIT] = (init_state == fifo_flags_pkg::INIT_DONE);
            next_rdata[`FFL_COUNT_MSB:0] = byte_count;
        end else if (reg_req.addr == `FFL_ADDR_SLOTS) begin
            next_rdata[`FFL_SLOT_COUNT-1:0] = slot_flags_reg;
        end else if (reg_req.addr == `FFL_ADDR_LIMIT) begin
            next_rdata[`FFL_LIMIT_W-1:0] = queue_fill_limit;
        end else if (reg_req.addr == `FFL_ADDR_ACLEAR) begin
            next_rdata[`FFL_BIT_ACLEAR] = fill_flag_autoclear_en;
        end else if (reg_req.addr == `FFL_ADDR_DATA && pop) begin
            // an empty read returns zero, which is harmless
            next_rdata[WIDTH-1:0] = fifo_out_data;
        end
    end

    // answer registered one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.rd;
            reg_rsp.data <= reg_req.rd ? next_rdata : '0;
        end
    end
endmodule

//--- bench/fifo_flags_props.sv
// port-level checks for the fifo status block
`timescale 1ns/10ps
`include "fifo_flags_consts.svh"
module fifo_flags_props #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register port
    input wire fifo_flags_pkg::reg_req_t reg_req,
    input wire fifo_flags_pkg::reg_rsp_t reg_rsp,
    // stream
    input wire logic acq_busy,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_ready,
    // slot events and flags
    input wire logic [`FFL_SLOT_COUNT-1:0] slot_update_hit,
    input wire logic [`FFL_SLOT_COUNT-1:0] tia1_sat_hit,
    input wire logic queue_fill_flag,
    input wire logic [`FFL_SLOT_COUNT-1:0] slot_flags_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // any slot event, update or saturation
    wire [`FFL_SLOT_COUNT-1:0] hits = slot_update_hit | tia1_sat_hit;
    // ============================================================
    // steps of a read, a cycle with no push and the clearing writes
    sequence s_read;
        reg_req.rd;
    endsequence
    sequence s_no_push;
        !(in_valid && in_ready);
    endsequence
    sequence s_slot_clear;
        reg_req.wr && reg_req.addr == `FFL_ADDR_SLOTS;
    endsequence
    sequence s_fill_clear;
        reg_req.wr && reg_req.addr == `FFL_ADDR_STATUS && reg_req.wdata[`FFL_BIT_FILL];
    endsequence
    // ============================================================
    // register answers
    a_read_gets_answer: assert property (s_read |=> reg_rsp.valid)
        else $error("read got no answer");
    a_answer_needs_read: assert property (reg_rsp.valid |-> $past(reg_req.rd))
        else $error("answer without read");
    a_flush_reads_zero: assert property (
        s_read and reg_req.addr == `FFL_ADDR_STATUS |=> !reg_rsp.data[`FFL_BIT_FLUSH])
        else $error("flush bit read as one");
    // slot flags
    a_slot_sets: assert property (
        |hits |=> (slot_flags_reg & $past(hits)) == $past(hits))
        else $error("slot flag missed its event");
    a_slot_no_spurious: assert property (
        (slot_flags_reg & ~$past(slot_flags_reg) & ~$past(hits)) == 0)
        else $error("slot flag rose without event");
    a_slot_w1c_clears: assert property (
        s_slot_clear |=> (slot_flags_reg & $past(reg_req.wdata[11:0] & ~hits)) == 0)
        else $error("slot flag not cleared");
    // fill flag
    a_fill_rise_push: assert property (
        $rose(queue_fill_flag) |-> $past(in_valid && in_ready))
        else $error("fill flag rose without push");
    a_fill_w1c_clears: assert property (
        s_fill_clear and s_no_push |=> !queue_fill_flag)
        else $error("fill flag not cleared");
    // self-init ends with the stream open
    a_ready_after_init: assert property ($fell(srst) |-> ##[1:20] in_ready)
        else $error("stream never opened after reset");
endmodule

//--- bench/host_model.sv
// host side of the register strobe port
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output fifo_flags_pkg::reg_req_t reg_req,
    input wire fifo_flags_pkg::reg_rsp_t reg_rsp
);
    // idle at time zero
    initial reg_req = '0;
    // one write strobe; on release address and data flip so stale values are never trusted
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_req <= {1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b0, ~a, ~d};
    endtask
    // one read strobe, then a bounded wait for the answer
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b0, ~a, 16'hFFFF};
        do begin
            @(posedge ref_clk);
            n++;
        end while (reg_rsp.valid !== 1'b1 && n < 4);
        // a missed answer hands back unknown so that the compare fails
        d = (reg_rsp.valid === 1'b1) ? reg_rsp.data : 16'hXXXX;
    endtask
endmodule

//--- bench/fifo_and_slot_interrupt_status_tb.sv
// self-checking bench for the fifo status block
`timescale 1ns/10ps
`include "fifo_flags_consts.svh"
module fifo_and_slot_interrupt_status_tb;
    // ============================================================
    // signals
    logic ref_clk, srst, acq_busy, in_valid, in_ready, queue_fill_flag;
    logic [7:0] in_data;
    logic [11:0] slot_update_hit, tia1_sat_hit, slot_flags_reg, m, w;
    fifo_flags_pkg::reg_req_t reg_req;
    fifo_flags_pkg::reg_rsp_t reg_rsp;
    int error_cnt = 0;
    int checks_done = 0;
    int lim;
    logic [15:0] rdv;
    logic [7:0] sent[$]; // bytes in the fifo, oldest first
    // clock at 125 MHz
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    fifo_flags_top dut_u (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .acq_busy(acq_busy), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .slot_update_hit(slot_update_hit), .tia1_sat_hit(tia1_sat_hit),
        .queue_fill_flag(queue_fill_flag), .slot_flags_reg(slot_flags_reg));
    host_model host_u (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
    // ============================================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input string what, input logic [9:0] a, input logic [15:0] exp);
        host_u.rd(a, rdv);
        check(what, rdv, exp);
    endtask
    // expected status word once self-init is done
    function automatic logic [15:0] stat(int u, int o, int f, int c);
        return {1'b0, 1'(u), 1'(o), 1'(f), 1'b1, 11'(c)};
    endfunction
    // offers k random bytes back to back, remembering each
    task automatic push(input int k);
        logic [7:0] b;
        repeat (k) begin
            b = 8'($urandom);
            sent.push_back(b);
            in_valid <= 1'b1;
            in_data <= b;
            @(posedge ref_clk);
        end
        in_valid <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #40000;
        error_cnt++;
        end_of_test();
    end
    // ============================================================
    // tests
    initial begin
        srst = 1'b1;
        acq_busy = 1'b0;
        in_valid = 1'b0;
        in_data = 8'h00;
        slot_update_hit = '0;
        tia1_sat_hit = '0;
        lim = $urandom(82835);
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk("status_early", `FFL_ADDR_STATUS, 16'h0000);
        rd_chk("limit_rst", `FFL_ADDR_LIMIT, 16'h000C);
        rd_chk("aclear_rst", `FFL_ADDR_ACLEAR, 16'h8000);
        rd_chk("slots_rst", `FFL_ADDR_SLOTS, 16'h0000);
        repeat (20) @(posedge ref_clk);
        rd_chk("status_init", `FFL_ADDR_STATUS, 16'h0800);
        rd_chk("empty_data", `FFL_ADDR_DATA, 16'h0000);
        rd_chk("underflow", `FFL_ADDR_STATUS, stat(1, 0, 0, 0));
        host_u.wr(`FFL_ADDR_STATUS, 16'h4000);
        rd_chk("underflow_clr", `FFL_ADDR_STATUS, stat(0, 0, 0, 0));
        $display("test reset and underflow done");
        // fill limit: equal count is not above it
        lim = 2 + $urandom_range(8);
        host_u.wr(`FFL_ADDR_LIMIT, 16'(lim));
        rd_chk("limit_wr", `FFL_ADDR_LIMIT, 16'(lim));
        push(lim);
        rd_chk("at_limit", `FFL_ADDR_STATUS, stat(0, 0, 0, lim));
        push(1);
        // the flag is launched at the edge that takes the byte; look one edge later
        @(posedge ref_clk);
        check("fill_set", 16'(queue_fill_flag), 16'h0001);
        rd_chk("data_first", `FFL_ADDR_DATA, 16'(sent.pop_front()));
        check("fill_autoclr", 16'(queue_fill_flag), 16'h0000);
        host_u.wr(`FFL_ADDR_ACLEAR, 16'h0000);
        rd_chk("aclear_wr", `FFL_ADDR_ACLEAR, 16'h0000);
        push(1);
        rd_chk("data_next", `FFL_ADDR_DATA, 16'(sent.pop_front()));
        check("fill_kept", 16'(queue_fill_flag), 16'h0001);
        host_u.wr(`FFL_ADDR_STATUS, 16'h1000);
        @(posedge ref_clk);
        check("fill_w1c", 16'(queue_fill_flag), 16'h0000);
        $display("test fill limit done");
        // fill to the brim, then offer one more byte
        push(16 - lim);
        @(posedge ref_clk);
        check("full_ready", 16'(in_ready), 16'h0000);
        push(1);
        rd_chk("overflow", `FFL_ADDR_STATUS, stat(0, 1, 1, 16));
        host_u.wr(`FFL_ADDR_STATUS, 16'h2000);
        rd_chk("overflow_clr", `FFL_ADDR_STATUS, stat(0, 0, 1, 16));
        push(1);
        acq_busy <= 1'b1;
        host_u.wr(`FFL_ADDR_STATUS, 16'h8000);
        rd_chk("flush_busy", `FFL_ADDR_STATUS, stat(0, 1, 1, 16));
        acq_busy <= 1'b0;
        host_u.wr(`FFL_ADDR_STATUS, 16'h8000);
        rd_chk("flush", `FFL_ADDR_STATUS, stat(0, 0, 0, 0));
        sent.delete();
        $display("test overflow and flush done");
        // each slot in turn, updates and saturations alternating
        for (int i = 0; i < 12; i++) begin
            m = 12'h001 << i;
            if (i % 2 == 1) tia1_sat_hit <= m;
            else slot_update_hit <= m;
            @(posedge ref_clk);
            tia1_sat_hit <= '0;
            slot_update_hit <= '0;
            rd_chk("slot_set", `FFL_ADDR_SLOTS, 16'(m));
            check("slot_pin", 16'(slot_flags_reg), 16'(m));
            host_u.wr(`FFL_ADDR_SLOTS, 16'(m));
        end
        // every slot set, split randomly between updates and saturations, then a random partial clear
        m = 12'($urandom);
        w = 12'($urandom);
        slot_update_hit <= m;
        tia1_sat_hit <= ~m;
        @(posedge ref_clk);
        slot_update_hit <= '0;
        tia1_sat_hit <= '0;
        host_u.wr(`FFL_ADDR_SLOTS, 16'(w));
        // invert before widening so the unused upper bits stay zero
        rd_chk("slot_partial", `FFL_ADDR_SLOTS, {4'h0, ~w});
        rd_chk("unmapped", 10'h3FF, 16'h0000);
        $display("test slot flags done");
        end_of_test();
    end
endmodule
bind fifo_flags_top fifo_flags_props #(.DEPTH(DEPTH), .WIDTH(WIDTH)) props_u (
    .ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp), .acq_busy(acq_busy),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .slot_update_hit(slot_update_hit), .tia1_sat_hit(tia1_sat_hit),
    .queue_fill_flag(queue_fill_flag), .slot_flags_reg(slot_flags_reg));
